// *** verilog/clock_synth_regs.svh ***
`ifndef CLOCK_SYNTH_REGS_SVH
`define CLOCK_SYNTH_REGS_SVH

// ==========================================
// register offsets
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define MASK_OFFSET 4'h8

// ==========================================
// control register fields
`define CTRL_W_BIT 15
`define CTRL_X_BIT 14
`define CTRL_Y_MSB 13
`define CTRL_Y_LSB 8
`define CTRL_LOSS_RST_BIT 7
`define CTRL_LOSS_BIT 4
`define CTRL_LOCK_BIT 3
`define CTRL_KEEP_EXT_BIT 1
`define CTRL_KEEP_INT_BIT 0
`define CTRL_WR_MASK 16'hFF83
`define CTRL_RESET 16'h3F00

// ==========================================
// event status and mask fields
`define EVT_LOSS_BIT 0
`define EVT_LOCK_BIT 1
`define EVT_MASK 16'h0003
`define MASK_RESET 16'h0000

// ==========================================
// loop model and timing
`define VCO_INIT_PERIOD 16'h0040
`define LIMP_PERIOD 16'h0002
`define LOCK_COUNT 3'h4
`define POST_DIV_LAST 4'hF
`define PRESCALE_LAST 2'h3
`define CLK_PERIOD_NS 10
`define REF_LOSS_TIME_NS 100000

`endif

// *** verilog/clock_synth_pkg.sv ***
package clock_synth_pkg;

    // gray order along crystal -> limp; external modes off the usual path
    typedef enum logic [1:0] {
        MODE_CRYSTAL = 2'b00,
        MODE_LIMP = 2'b01,
        MODE_EXT_PLL = 2'b11,
        MODE_EXT_DIRECT = 2'b10
    } clock_mode_t;

endpackage

// *** verilog/synth_loop_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface synth_loop_if;
    logic prescale_w;
    logic [5:0] div_y;
    logic limp;
    logic ref_edge;
    logic vco_tick;
    logic locked;
    logic ref_lost;

    modport ctrl (
        output prescale_w, div_y, limp, ref_edge,
        input vco_tick, locked, ref_lost
    );
    modport loop (
        input prescale_w, div_y, limp, ref_edge,
        output vco_tick, locked, ref_lost
    );
endinterface

`default_nettype wire

// *** verilog/synth_loop.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "clock_synth_regs.svh"

module synth_loop #(
    parameter int unsigned REF_LOSS_CYCLES = 10000
) (
    input wire logic clock_i,
    input wire logic rst_i,
    synth_loop_if.loop lp
);
    logic [15:0] period_q, vco_cnt_q;
    logic vco_tick_q, lost_q;
    logic [1:0] pre_q, fb_cnt_q;
    logic [5:0] down_q;
    logic [3:0] post_q;
    logic [2:0] lock_cnt_q;
    logic [31:0] wd_q;
    logic pre_carry, down_carry, fb_tick;

    // ==========================================
    // oscillator model: one tick every period_q clocks
    always_ff @(posedge clock_i) begin
        if (rst_i || vco_cnt_q >= period_q - 16'h0001) begin
            vco_cnt_q <= 16'h0000;
            vco_tick_q <= !rst_i;
        end else begin
            vco_cnt_q <= vco_cnt_q + 16'h0001;
            vco_tick_q <= 1'b0;
        end
    end
    assign lp.vco_tick = vco_tick_q;

    // ==========================================
    // feedback divider: prescaler, modulo downcounter, fixed divide by sixteen
    // R9: prescale then downcount
    assign pre_carry = vco_tick_q && (!lp.prescale_w || pre_q == `PRESCALE_LAST);
    assign down_carry = pre_carry && down_q == 6'h00;
    // R10: 16(Y+1)4^W ticks, two per oscillator cycle
    assign fb_tick = down_carry && post_q == `POST_DIV_LAST;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pre_q <= 2'h0;
            down_q <= 6'h00;
            post_q <= 4'h0;
        end else begin
            if (vco_tick_q)
                pre_q <= lp.prescale_w ? pre_q + 2'h1 : 2'h0;
            if (pre_carry)
                down_q <= (down_q == 6'h00) ? lp.div_y : down_q - 6'h01;
            if (down_carry)
                post_q <= post_q + 4'h1;
        end
    end

    // ==========================================
    // phase comparison, one decision per reference edge
    always_ff @(posedge clock_i) begin
        if (rst_i || lp.ref_edge)
            fb_cnt_q <= 2'h0;
        else if (fb_tick && fb_cnt_q != 2'h3)
            fb_cnt_q <= fb_cnt_q + 2'h1;
    end

    // R8: steer oscillator period
    always_ff @(posedge clock_i) begin
        if (rst_i)
            period_q <= `VCO_INIT_PERIOD;
        else if (lp.limp)
            period_q <= `LIMP_PERIOD;
        else if (lp.ref_edge && fb_cnt_q == 2'h0 && period_q > 16'h0001)
            period_q <= period_q - 16'h0001;
        else if (lp.ref_edge && fb_cnt_q >= 2'h2 && period_q != 16'hFFFF)
            period_q <= period_q + 16'h0001;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || lp.limp)
            lock_cnt_q <= 3'h0;
        else if (lp.ref_edge)
            lock_cnt_q <= (fb_cnt_q != 2'h1) ? 3'h0 :
                (lock_cnt_q == `LOCK_COUNT) ? lock_cnt_q : lock_cnt_q + 3'h1;
    end
    assign lp.locked = lock_cnt_q == `LOCK_COUNT;

    // ==========================================
    // reference watchdog; loss stays flagged until reset
    // R8: reference stop detect
    always_ff @(posedge clock_i) begin
        if (rst_i || lp.ref_edge)
            wd_q <= 32'h00000000;
        else if (wd_q != 32'hFFFFFFFF)
            wd_q <= wd_q + 32'h00000001;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i)
            lost_q <= 1'b0;
        else if (wd_q >= 32'(REF_LOSS_CYCLES) - 32'h00000001)
            lost_q <= 1'b1;
    end
    assign lp.ref_lost = lost_q;

    // ==========================================
    // checks
    chk_period_speedup: assert property (  // R8
        @(posedge clock_i) disable iff (rst_i)
        lp.ref_edge && fb_cnt_q == 2'h0 && !lp.limp && period_q > 16'h0001
        |=> period_q == $past(period_q) - 16'h0001)
        else $error("period not shortened on slow feedback");
    chk_limp_rate: assert property (  // R4
        @(posedge clock_i) disable iff (rst_i)
        lp.limp |=> period_q == `LIMP_PERIOD ##1 vco_cnt_q <= `LIMP_PERIOD)
        else $error("limp rate not applied");
    chk_loss_watchdog: assert property (  // R8
        @(posedge clock_i) disable iff (rst_i)
        wd_q == 32'(REF_LOSS_CYCLES) - 32'h00000001 |=> lost_q)
        else $error("reference loss not flagged");
endmodule

`default_nettype wire

// *** verilog/clock_synth_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "clock_synth_regs.svh"

// How it works
// R1: four clock modes chosen from reset strap; code picks three at reset from strap and supply, limp only on reference loss
// R2: direct mode passes oscillator input through
// R3: external PLL mode locks clock to input
// R4: limp mode runs oscillator near half speed
// R5: readable flag shows reference loss
// R6: loss reset enable picks reset or limp
// R7: lock flag on lock or direct clock
// R8: phase compare steers oscillator, detects stop
// R9: prescaler then six-bit downcounter feedback
// R10: system rate is ref*4(Y+1)*2^(2W+X)
// R11: X clear runs oscillator at twice system
// R12: stop bits pick internal and output sources
// R13: stopped clocks are held low
// R14: integration clock keeps running in stop
// R15: strap sampled only during reset
// R16: control register holds W, X, Y, flags
// R17: loss with enable asserts system reset
module clock_synth_ctrl #(
    parameter int unsigned REF_LOSS_CYCLES = `REF_LOSS_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clock_mode_strap_i,
    input wire logic synth_supply_i,
    input wire logic osc_input_i,
    input wire logic low_power_stop_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic osc_output_o,
    output logic osc_output_oe_o,
    output logic sys_clock_o,
    output logic clock_output_o,
    output logic integration_module_clock_o,
    output logic sys_reset_o,
    output logic irq_o,
    output clock_synth_pkg::clock_mode_t clock_mode_o
);
    import clock_synth_pkg::*;

    clock_mode_t mode_q;
    logic [15:0] ctrl_q, sts_q, msk_q, sts_set;
    logic osc_q, vco_clk_q, sys_gen_q, half_q, lock_prev_q, loss_prev_q;
    logic direct, pll_mode, ref_loss_flag, lock_flag, sys_tick;
    logic run_clk, stop_src, keep_int, keep_ext, loss_rst_en;

    synth_loop_if lp ();

    synth_loop #(
        .REF_LOSS_CYCLES(REF_LOSS_CYCLES)
    ) u_loop (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .lp(lp)
    );

    // ==========================================
    // mode selection
    assign direct = mode_q == MODE_EXT_DIRECT;
    assign pll_mode = mode_q == MODE_CRYSTAL || mode_q == MODE_EXT_PLL;
    assign loss_rst_en = ctrl_q[`CTRL_LOSS_RST_BIT];

    // R1: strap and supply pick mode
    // R15: sampled while reset held
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            if (clock_mode_strap_i)
                mode_q <= MODE_CRYSTAL;
            else
                mode_q <= synth_supply_i ? MODE_EXT_PLL : MODE_EXT_DIRECT;
        end else if (pll_mode && lp.ref_lost && !loss_rst_en) begin
            // R6: continue in limp
            mode_q <= MODE_LIMP;
        end
    end
    assign clock_mode_o = mode_q;

    // ==========================================
    // loop control
    assign lp.prescale_w = ctrl_q[`CTRL_W_BIT];
    assign lp.div_y = ctrl_q[`CTRL_Y_MSB:`CTRL_Y_LSB];
    // R4: limp forces fixed oscillator rate
    assign lp.limp = mode_q == MODE_LIMP;
    assign lp.ref_edge = osc_input_i && !osc_q && !direct;

    // R5: loss flag only where a loop runs
    assign ref_loss_flag = !direct && lp.ref_lost;
    // R7: lock or direct clock
    assign lock_flag = direct || (pll_mode && lp.locked);

    // R17: loss with enable resets system
    always_ff @(posedge clock_i) begin
        if (rst_i)
            sys_reset_o <= 1'b0;
        else
            sys_reset_o <= pll_mode && lp.ref_lost && loss_rst_en;
    end

    // ==========================================
    // clock generation
    // R11: with X clear, halve oscillator ticks
    assign sys_tick = lp.vco_tick && (ctrl_q[`CTRL_X_BIT] || half_q);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            osc_q <= 1'b0;
            half_q <= 1'b0;
            vco_clk_q <= 1'b0;
            sys_gen_q <= 1'b0;
        end else begin
            osc_q <= osc_input_i;
            if (lp.vco_tick) begin
                half_q <= !half_q;
                vco_clk_q <= !vco_clk_q;
            end
            if (sys_tick)
                sys_gen_q <= !sys_gen_q;
        end
    end

    // R2: direct mode uses input as is
    // R3: PLL modes use locked oscillator
    assign run_clk = direct ? osc_input_i : sys_gen_q;
    assign keep_int = ctrl_q[`CTRL_KEEP_INT_BIT];
    assign keep_ext = ctrl_q[`CTRL_KEEP_EXT_BIT];
    // R12: stop source selection
    assign stop_src = (keep_int && !direct) ? vco_clk_q : osc_input_i;

    // R13: stopped clocks driven low
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sys_clock_o <= 1'b0;
            clock_output_o <= 1'b0;
        end else if (low_power_stop_i) begin
            sys_clock_o <= 1'b0;
            // R12: output off or same source
            clock_output_o <= keep_ext && stop_src;
        end else begin
            sys_clock_o <= run_clk;
            clock_output_o <= run_clk;
        end
    end

    // R14: integration clock never stops
    always_ff @(posedge clock_i) begin
        if (rst_i)
            integration_module_clock_o <= 1'b0;
        else
            integration_module_clock_o <= low_power_stop_i ? stop_src : run_clk;
    end

    // crystal amplifier drives in crystal and limp modes; external sources float it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            osc_output_o <= 1'b0;
            osc_output_oe_o <= 1'b0;
        end else begin
            osc_output_o <= !osc_input_i;
            osc_output_oe_o <= mode_q == MODE_CRYSTAL || mode_q == MODE_LIMP;
        end
    end

    // ==========================================
    // registers
    // one address decoder shared by the strobes and the checks
    function automatic logic hit(input logic [3:0] a, input logic [3:0] offset);
        return a == offset;
    endfunction

    // R16: writable W, X, Y and control bits
    always_ff @(posedge clock_i) begin
        if (rst_i)
            ctrl_q <= `CTRL_RESET;
        else if (wr_i && hit(addr_i, `CTRL_OFFSET))
            ctrl_q <= wdata_i & `CTRL_WR_MASK;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i)
            msk_q <= `MASK_RESET;
        else if (wr_i && hit(addr_i, `MASK_OFFSET))
            msk_q <= wdata_i & `EVT_MASK;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lock_prev_q <= 1'b0;
            loss_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= lock_flag;
            loss_prev_q <= ref_loss_flag;
        end
    end

    always_comb begin
        sts_set = 16'h0000;
        sts_set[`EVT_LOSS_BIT] = ref_loss_flag && !loss_prev_q;
        sts_set[`EVT_LOCK_BIT] = lock_flag && !lock_prev_q;
    end

    // a new event in the clearing read cycle survives
    always_ff @(posedge clock_i) begin
        if (rst_i)
            sts_q <= 16'h0000;
        else if (rd_i && hit(addr_i, `STATUS_OFFSET))
            sts_q <= sts_set;
        else
            sts_q <= sts_q | sts_set;
    end

    assign irq_o = |(sts_q & msk_q);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                // R5: loss flag readable
                // R7: lock flag readable
                `CTRL_OFFSET: begin
                    rdata_o <= ctrl_q;
                    rdata_o[`CTRL_LOSS_BIT] <= ref_loss_flag;
                    rdata_o[`CTRL_LOCK_BIT] <= lock_flag;
                end
                `STATUS_OFFSET: rdata_o <= sts_q;
                `MASK_OFFSET: rdata_o <= msk_q;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ==========================================
    // checks
    chk_strap_ignored: assert property (  // R15
        @(posedge clock_i) disable iff (rst_i)
        !$past(rst_i) |-> direct == $past(direct))
        else $error("mode changed by strap after reset");
    chk_direct_pass: assert property (  // R2
        @(posedge clock_i) disable iff (rst_i)
        direct && !low_power_stop_i |=> sys_clock_o == $past(osc_input_i)
            && clock_output_o == $past(osc_input_i))
        else $error("direct mode clock not passed through");
    chk_stop_low: assert property (  // R13
        @(posedge clock_i) disable iff (rst_i)
        low_power_stop_i && !keep_ext |=> !sys_clock_o && !clock_output_o)
        else $error("stopped clock not held low");
    chk_stop_int_src: assert property (  // R12
        @(posedge clock_i) disable iff (rst_i)
        low_power_stop_i && !keep_int
        |=> integration_module_clock_o == $past(osc_input_i))
        else $error("integration clock source wrong in stop");
    chk_stop_ext_follow: assert property (  // R12
        @(posedge clock_i) disable iff (rst_i)
        low_power_stop_i && keep_ext
        |=> clock_output_o == integration_module_clock_o)
        else $error("clock output not following stop source");
    chk_loss_reset: assert property (  // R17
        @(posedge clock_i) disable iff (rst_i)
        pll_mode && lp.ref_lost && loss_rst_en |=> sys_reset_o && mode_q != MODE_LIMP)
        else $error("loss did not reset system");
    chk_limp_entry: assert property (  // R6
        @(posedge clock_i) disable iff (rst_i)
        pll_mode && lp.ref_lost && !loss_rst_en |=> mode_q == MODE_LIMP ##1 !sys_reset_o)
        else $error("loss did not enter limp");
    chk_flags_read: assert property (  // R5
        @(posedge clock_i) disable iff (rst_i)
        rd_i && hit(addr_i, `CTRL_OFFSET)
        |=> rdata_o[`CTRL_LOSS_BIT] == $past(ref_loss_flag)
            && rdata_o[`CTRL_LOCK_BIT] == $past(lock_flag))
        else $error("control flags misreported");
    chk_direct_lock: assert property (  // R7
        @(posedge clock_i) disable iff (rst_i)
        direct |-> lock_flag && !ref_loss_flag)
        else $error("direct mode lock flag wrong");
    // events, amplifier drive and stop levels as software and the board see them
    chk_read_clears: assert property (  // R5
        @(posedge clock_i) disable iff (rst_i)
        rd_i && hit(addr_i, `STATUS_OFFSET) && sts_set == 16'h0000
        |=> sts_q == 16'h0000)
        else $error("status read did not clear events");
    chk_loss_event: assert property (  // R5
        @(posedge clock_i) disable iff (rst_i)
        ref_loss_flag && !loss_prev_q |=> sts_q[`EVT_LOSS_BIT])
        else $error("loss event not recorded");
    chk_ext_float: assert property (  // R2
        @(posedge clock_i) disable iff (rst_i)
        direct || mode_q == MODE_EXT_PLL
        |=> !osc_output_oe_o)
        else $error("oscillator output driven with external clock");
    chk_stop_sys_low: assert property (  // R13
        @(posedge clock_i) disable iff (rst_i)
        low_power_stop_i |=> !sys_clock_o)
        else $error("system clock running in stop");
endmodule

`default_nettype wire

// *** test/ref_source_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// reference source: crystal or oscillator at the far side
module ref_source_model #(
    parameter int unsigned HALF = 20
) (
    input wire logic clock_i,
    input wire logic run_i,
    output logic osc_o
);
    int unsigned count_q = 0;
    logic osc_q = 1'b0;

    assign osc_o = osc_q;

    // a stopped source settles low instead of freezing mid-swing
    always @(posedge clock_i) begin
        if (!run_i) begin
            count_q <= 0;
            osc_q <= 1'b0;
        end else if (count_q == HALF - 1) begin
            count_q <= 0;
            osc_q <= ~osc_q;
        end else begin
            count_q <= count_q + 1;
        end
    end
endmodule

`default_nettype wire

// *** test/clock_synth_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "clock_synth_regs.svh"

module clock_synth_ctrl_test;
    import clock_synth_pkg::*;
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [15:0] wdata;
        logic [15:0] mask;
        logic [15:0] exp;
    } row_t;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic strap = 1'b1;
    logic supply = 1'b1;
    logic stop = 1'b0;
    logic run = 1'b1;
    logic osc_in;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic sys_clock_o;
    logic clock_output_o;
    logic imc_o;
    logic xo;
    logic xo_oe;
    logic sys_reset_o;
    logic irq_o;
    clock_mode_t mode_o;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int t;
    logic [15:0] rd;
    logic p;
    row_t rows [8];

    always #5 clock_i = ~clock_i;

    // reference period of 80 clocks lets the loop settle on a whole oscillator period
    ref_source_model #(.HALF(40)) ref_source_model_i (.clock_i(clock_i), .run_i(run),
        .osc_o(osc_in));

    // loss time cut down so a stopped reference shows within a few hundred cycles
    clock_synth_ctrl #(.REF_LOSS_CYCLES(200)) clock_synth_ctrl_i (.clock_i(clock_i),
        .rst_i(rst_i), .clock_mode_strap_i(strap), .synth_supply_i(supply),
        .osc_input_i(osc_in), .low_power_stop_i(stop), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_output_o(xo), .osc_output_oe_o(xo_oe),
        .sys_clock_o(sys_clock_o), .clock_output_o(clock_output_o),
        .integration_module_clock_o(imc_o), .sys_reset_o(sys_reset_o), .irq_o(irq_o),
        .clock_mode_o(mode_o));

    // ==========================================
    // helpers
    task automatic conclude();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic do_reset(input logic s, input logic v);
        @(posedge clock_i);
        rst_i <= 1'b1;
        strap <= s;
        supply <= v;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
    endtask

    task automatic count_toggles(input int n, output int c);
        logic last;
        c = 0;
        last = sys_clock_o;
        repeat (n) begin
            @(posedge clock_i);
            #1;
            if (sys_clock_o !== last) c++;
            last = sys_clock_o;
        end
    endtask

    task automatic follow(input int n, input logic want_sys);
        repeat (n) begin
            @(posedge clock_i);
            p = osc_in;
            #1;
            check("clock out", {15'h0, p}, {15'h0, clock_output_o});
            check("sys clock", {15'h0, p & want_sys}, {15'h0, sys_clock_o});
            if (!want_sys) check("int clock", {15'h0, p}, {15'h0, imc_o});
            check("osc amp", {15'h0, ~p}, {15'h0, xo});
        end
    endtask

    // hang guard: whole run needs well under this many cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            conclude();
        end
    end

    // ==========================================
    // sequence
    initial begin
        rows[0] = {1'b0, `CTRL_OFFSET, 16'h0000, 16'hFFE7, `CTRL_RESET};
        rows[1] = {1'b0, `STATUS_OFFSET, 16'h0000, 16'hFFFF, 16'h0000};
        rows[2] = {1'b0, `MASK_OFFSET, 16'h0000, 16'hFFFF, `MASK_RESET};
        rows[3] = {1'b1, `CTRL_OFFSET, 16'hFFFF, 16'hFFE7, 16'hFF83};
        rows[4] = {1'b1, `MASK_OFFSET, 16'hFFFF, 16'hFFFF, 16'h0003};
        rows[5] = {1'b1, 4'hC, 16'hFFFF, 16'hFFFF, 16'h0000};
        rows[6] = {1'b1, `CTRL_OFFSET, 16'h4000, 16'hFFE7, 16'h4000};
        rows[7] = {1'b1, `MASK_OFFSET, 16'h0002, 16'hFFFF, 16'h0002};
        do_reset(1'b1, 1'b1);
        repeat (2) @(posedge clock_i);
        check("mode", {14'h0, MODE_CRYSTAL}, {14'h0, mode_o});
        for (int i = 0; i < 8; i++) begin
            if (rows[i].wr) write_reg(rows[i].addr, rows[i].wdata);
            read_reg(rows[i].addr, rd);
            check("reg", rows[i].exp, rd & rows[i].mask);
        end
        for (int i = 0; i < 9000 && irq_o !== 1'b1; i++) @(posedge clock_i);
        // the loop may lock briefly on its way down; let it settle on the final rate
        repeat (1200) @(posedge clock_i);
        read_reg(`STATUS_OFFSET, rd);
        check("lock event", 16'h0002, rd & 16'h0002);
        read_reg(`CTRL_OFFSET, rd);
        check("lock flag", 16'h0008, rd & 16'h0018);
        check("irq clear", 16'h0000, {15'h0, irq_o});
        check("osc drive", 16'h0001, {15'h0, xo_oe});
        // five reference periods at Y=0 W=0 X=1: system at 4*1*2 times reference, 16 toggles each
        count_toggles(400, t);
        check("sys rate", 16'h0001, {15'h0, t >= 76 && t <= 84});
        write_reg(`CTRL_OFFSET, 16'h4002);
        stop <= 1'b1;
        repeat (2) @(posedge clock_i);
        follow(50, 1'b0);
        write_reg(`CTRL_OFFSET, 16'h4000);
        repeat (2) @(posedge clock_i);
        repeat (20) begin
            @(posedge clock_i);
            #1;
            check("clock out off", 16'h0000, {15'h0, clock_output_o});
        end
        stop <= 1'b0;
        write_reg(`MASK_OFFSET, 16'h0001);
        run <= 1'b0;
        for (int i = 0; i < 400 && mode_o !== MODE_LIMP; i++) @(posedge clock_i);
        #1;
        check("limp mode", {14'h0, MODE_LIMP}, {14'h0, mode_o});
        check("loss irq", 16'h0001, {15'h0, irq_o});
        check("no reset", 16'h0000, {15'h0, sys_reset_o});
        read_reg(`CTRL_OFFSET, rd);
        check("loss flag", 16'h0010, rd & 16'h0010);
        count_toggles(40, t);
        check("limp rate", 16'h0001, {15'h0, t >= 19 && t <= 21});
        run <= 1'b1;
        do_reset(1'b1, 1'b1);
        write_reg(`CTRL_OFFSET, 16'h4080);
        repeat (100) @(posedge clock_i);
        run <= 1'b0;
        for (int i = 0; i < 400 && sys_reset_o !== 1'b1; i++) @(posedge clock_i);
        #1;
        check("loss reset", 16'h0001, {15'h0, sys_reset_o});
        check("no limp", {14'h0, MODE_CRYSTAL}, {14'h0, mode_o});
        run <= 1'b1;
        do_reset(1'b0, 1'b0);
        strap <= 1'b1;
        repeat (3) @(posedge clock_i);
        check("direct mode", {14'h0, MODE_EXT_DIRECT}, {14'h0, mode_o});
        check("osc float", 16'h0000, {15'h0, xo_oe});
        read_reg(`CTRL_OFFSET, rd);
        check("direct flags", 16'h0008, rd & 16'h0018);
        follow(60, 1'b1);
        do_reset(1'b0, 1'b1);
        repeat (2) @(posedge clock_i);
        check("ext pll mode", {14'h0, MODE_EXT_PLL}, {14'h0, mode_o});
        conclude();
    end
endmodule

`default_nettype wire
